// ### loop_branch_pkg.sv
package loop_branch_pkg;

    // First-byte encodings; partial fields hold only the fixed upper bits
    localparam logic [4:0] OP_DEC_BR_REG_HI = 5'h1b;
    localparam logic [7:0] OP_DEC_BR_DIR    = 8'hd5;
    localparam logic [7:0] OP_INC_ACC       = 8'h04;
    localparam logic [4:0] OP_INC_REG_HI    = 5'h01;
    localparam logic [7:0] OP_INC_DIR       = 8'h05;
    localparam logic [6:0] OP_INC_IND_HI    = 7'h03;
    localparam logic [7:0] OP_INC_PTR       = 8'ha3;
    localparam logic [7:0] OP_BIT_JUMP      = 8'h20;
    localparam logic [7:0] OP_CLEAR_JUMP    = 8'h10;
    localparam logic [7:0] OP_CARRY_JUMP    = 8'h40;
    localparam logic [7:0] OP_JMP_IND       = 8'h73;

    // Field positions inside the opcode
    localparam int REG_SEL_MSB = 2;
    localparam int IND_SEL_BIT = 0;

    // Instruction lengths in bytes
    localparam logic [1:0] LEN_ONE   = 2'd1;
    localparam logic [1:0] LEN_TWO   = 2'd2;
    localparam logic [1:0] LEN_THREE = 2'd3;

    // Machine cycles per instruction
    localparam logic [1:0] CYC_ONE = 2'd1;
    localparam logic [1:0] CYC_TWO = 2'd2;

    // Byte and word arithmetic
    localparam logic [7:0]  BYTE_ONE  = 8'h01;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ONE  = 16'h0001;

    // Values after reset
    localparam logic [15:0] PC_RESET   = 16'h0000;
    localparam logic [15:0] POINTER_RESET = 16'h0000;
    localparam logic [7:0]  DATA_RESET = 8'h00;

    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_ACC,
        TGT_REG,
        TGT_DIRECT,
        TGT_INDIRECT
    } target_e;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_SECOND
    } exec_state_e;

endpackage

// ### loop_increment_branch_exec.sv
// Operation
// RULE1: Decrement wraps, branch if nonzero, flags kept
// RULE2: Advance past instruction, then add displacement
// RULE3: Register form two bytes, direct three, two cycles
// RULE4: Port operand read from output latch
// RULE5: Byte increment wraps, no flag changes
// RULE6: Four increment forms, one cycle each
// RULE7: Pointer increment sixteen bit, two cycles
// RULE8: Bit set: advance three, branch if one
// RULE9: Bit set: clear bit and branch, else fall
// RULE10: Clear-test of port bit uses output latch
// RULE11: Carry set: advance two, branch by byte two
// RULE12: Indirect jump: accumulator plus pointer into counter
// RULE13: Decode listed first-byte opcodes and fields
module loop_increment_branch_exec
    import loop_branch_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        start,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  operand_1,
    input  wire logic [7:0]  operand_2,
    input  wire logic [15:0] pc,
    input  wire logic [7:0]  acc,
    input  wire logic [15:0] data_pointer,
    input  wire logic        carry,
    input  wire logic [7:0]  reg_value,
    input  wire logic [7:0]  mem_value,
    input  wire logic [7:0]  latch_value,
    input  wire logic        operand_is_port,
    input  wire logic        bit_pin,
    input  wire logic        bit_latch,
    input  wire logic        bit_is_port,
    output logic             busy,
    output logic             done,
    output logic             unknown_op,
    output logic [15:0]      pc_next,
    output logic             branch_taken,
    output logic [1:0]       instr_length,
    output logic             wr_en,
    output target_e          wr_target,
    output logic [2:0]       reg_select,
    output logic             ind_select,
    output logic [7:0]       wr_data,
    output logic             pointer_wr,
    output logic [15:0]      pointer_out,
    output logic             bit_clear
);

    function automatic logic [15:0] advance(input logic [15:0] base, input logic [1:0] len);
        return base + {14'h0000, len};
    endfunction

    function automatic logic [15:0] rel_add(input logic [15:0] base, input logic [7:0] rel);
        return base + {{8{rel[7]}}, rel};
    endfunction

    exec_state_e state_reg;
    exec_state_e state_next;

    logic        busy_reg;
    logic        done_reg;
    logic        unknown_op_reg;
    logic [15:0] pc_next_reg;
    logic        branch_taken_reg;
    logic [1:0]  instr_length_reg;
    logic        wr_en_reg;
    target_e     wr_target_reg;
    logic [2:0]  reg_select_reg;
    logic        ind_select_reg;
    logic [7:0]  wr_data_reg;
    logic        pointer_wr_reg;
    logic [15:0] pointer_out_reg;
    logic        bit_clear_reg;
    logic        pend_wr_reg;
    logic        pend_ptr_reg;
    logic        pend_clr_reg;

    // Decode
    wire is_dec_br_reg = opcode[7:3] == OP_DEC_BR_REG_HI; // RULE13
    wire is_dec_br_dir = opcode == OP_DEC_BR_DIR; // RULE13
    wire is_inc_acc    = opcode == OP_INC_ACC; // RULE13
    wire is_inc_reg    = opcode[7:3] == OP_INC_REG_HI; // RULE13
    wire is_inc_dir    = opcode == OP_INC_DIR; // RULE13
    wire is_inc_ind    = opcode[7:1] == OP_INC_IND_HI; // RULE13
    wire is_inc_ptr    = opcode == OP_INC_PTR; // RULE13
    wire is_bit_jump   = opcode == OP_BIT_JUMP; // RULE13
    wire is_clear_jump = opcode == OP_CLEAR_JUMP; // RULE13
    wire is_carry_jump = opcode == OP_CARRY_JUMP; // RULE13
    wire is_jmp_ind    = opcode == OP_JMP_IND; // RULE13

    wire is_dec_br   = is_dec_br_reg | is_dec_br_dir;
    wire is_inc_byte = is_inc_acc | is_inc_reg | is_inc_dir | is_inc_ind; // RULE6
    wire is_known    = is_dec_br | is_inc_byte | is_inc_ptr | is_bit_jump |
                       is_clear_jump | is_carry_jump | is_jmp_ind;
    wire accept      = start & (state_reg == ST_IDLE);
    wire two_cycle   = is_known & ~is_inc_byte; // RULE3 RULE7 RULE8 RULE11 RULE12

    // Port bytes are modified from the latch so a loaded pin cannot corrupt them
    wire       reg_form  = is_dec_br_reg | is_inc_reg;
    wire [7:0] mem_src   = operand_is_port ? latch_value : mem_value; // RULE4
    wire [7:0] src_byte  = reg_form ? reg_value : (is_inc_acc ? acc : mem_src);
    wire [7:0] dec_byte  = src_byte - BYTE_ONE; // RULE1
    wire [7:0] inc_byte  = src_byte + BYTE_ONE; // RULE5

    // Plain bit test samples the pin; the clearing test sees the latch for port bits
    wire clear_test_bit = bit_is_port ? bit_latch : bit_pin; // RULE10

    wire [1:0] len = (is_dec_br_dir | is_bit_jump | is_clear_jump) ? LEN_THREE :
                     (is_dec_br_reg | is_carry_jump | is_inc_dir) ? LEN_TWO : LEN_ONE; // RULE3 RULE6
    wire [7:0] rel = (is_dec_br_reg | is_carry_jump) ? operand_1 : operand_2;

    wire taken = (is_dec_br & (dec_byte != BYTE_ZERO)) // RULE1
               | (is_bit_jump & bit_pin) // RULE8
               | (is_clear_jump & clear_test_bit) // RULE9
               | (is_carry_jump & carry); // RULE11

    wire [15:0] seq_pc    = advance(pc, len); // RULE2
    wire [15:0] jump_pc   = data_pointer + {8'h00, acc}; // RULE12
    wire [15:0] target_pc = is_jmp_ind ? jump_pc :
                            (taken ? rel_add(seq_pc, rel) : seq_pc); // RULE2 RULE8 RULE11

    wire target_e dec_target = is_inc_acc ? TGT_ACC :
                               reg_form ? TGT_REG :
                               is_inc_ind ? TGT_INDIRECT :
                               (is_dec_br_dir | is_inc_dir) ? TGT_DIRECT : TGT_NONE;
    wire dec_wr   = is_dec_br | is_inc_byte;
    wire dec_clr  = is_clear_jump & clear_test_bit; // RULE9

    wire finish_now = (accept & ~two_cycle) | (state_reg == ST_SECOND);
    wire fin_wr     = (state_reg == ST_SECOND) ? pend_wr_reg : dec_wr;
    wire fin_ptr    = (state_reg == ST_SECOND) ? pend_ptr_reg : 1'b0;
    wire fin_clr    = (state_reg == ST_SECOND) ? pend_clr_reg : 1'b0;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (accept && two_cycle) begin
                    state_next = ST_SECOND;
                end
            end
            ST_SECOND: state_next = ST_IDLE;
            default:   state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy_reg  <= state_next == ST_SECOND;
            done_reg  <= finish_now;
        end
    end

    // Effects are pulsed together with done
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_en_reg     <= 1'b0;
            pointer_wr_reg <= 1'b0;
            bit_clear_reg <= 1'b0;
        end else begin
            wr_en_reg     <= finish_now & fin_wr;
            pointer_wr_reg <= finish_now & fin_ptr; // RULE7
            bit_clear_reg <= finish_now & fin_clr; // RULE9
        end
    end

    // Results stand until the next accepted instruction
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            unknown_op_reg   <= 1'b0;
            pc_next_reg      <= PC_RESET;
            branch_taken_reg <= 1'b0;
            instr_length_reg <= LEN_ONE;
            wr_target_reg    <= TGT_NONE;
            reg_select_reg   <= 3'h0;
            ind_select_reg   <= 1'b0;
            wr_data_reg      <= DATA_RESET;
            pointer_out_reg  <= POINTER_RESET;
            pend_wr_reg      <= 1'b0;
            pend_ptr_reg     <= 1'b0;
            pend_clr_reg     <= 1'b0;
        end else if (accept) begin
            unknown_op_reg   <= ~is_known;
            pc_next_reg      <= is_known ? target_pc : pc;
            branch_taken_reg <= taken | is_jmp_ind;
            instr_length_reg <= len;
            wr_target_reg    <= dec_target;
            reg_select_reg   <= opcode[REG_SEL_MSB:0]; // RULE13
            ind_select_reg   <= opcode[IND_SEL_BIT]; // RULE13
            wr_data_reg      <= is_dec_br ? dec_byte : inc_byte; // RULE1 RULE5
            pointer_out_reg  <= data_pointer + WORD_ONE; // RULE7
            pend_wr_reg      <= dec_wr;
            pend_ptr_reg     <= is_inc_ptr; // RULE7
            pend_clr_reg     <= dec_clr;
        end
    end

    assign busy         = busy_reg;
    assign done         = done_reg;
    assign unknown_op   = unknown_op_reg;
    assign pc_next      = pc_next_reg;
    assign branch_taken = branch_taken_reg;
    assign instr_length = instr_length_reg;
    assign wr_en        = wr_en_reg;
    assign wr_target    = wr_target_reg;
    assign reg_select   = reg_select_reg;
    assign ind_select   = ind_select_reg;
    assign wr_data      = wr_data_reg;
    assign pointer_wr   = pointer_wr_reg;
    assign pointer_out  = pointer_out_reg;
    assign bit_clear    = bit_clear_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_two_cycle;
        busy_reg && !done_reg ##1 done_reg && !busy_reg;
    endsequence

    sequence s_one_cycle;
        done_reg && !busy_reg;
    endsequence

    sequence s_clear_pulse;
        done_reg && bit_clear_reg && !busy_reg;
    endsequence

    property p_dec_br_wrap;
        accept && is_dec_br && src_byte == 8'h00 |=> wr_data_reg == 8'hff && branch_taken_reg;
    endproperty
    a_dec_br_wrap: assert property (p_dec_br_wrap) else $error("decrement did not wrap zero"); // RULE1

    property p_dec_br_fall;
        accept && is_dec_br_dir && src_byte == 8'h01 |=> pc_next_reg == $past(pc) + 16'd3 && !branch_taken_reg;
    endproperty
    a_dec_br_fall: assert property (p_dec_br_fall) else $error("decrement to zero did not fall through"); // RULE2

    property p_dec_br_cycles;
        accept && is_dec_br |=> s_two_cycle ##0 wr_en_reg;
    endproperty
    a_dec_br_cycles: assert property (p_dec_br_cycles) else $error("decrement branch not two cycles"); // RULE3

    property p_port_latch;
        accept && is_inc_dir && operand_is_port |=> wr_data_reg == $past(latch_value) + 8'h01;
    endproperty
    a_port_latch: assert property (p_port_latch) else $error("port increment not from latch"); // RULE4

    property p_inc_wrap;
        accept && is_inc_byte && src_byte == 8'hff |=> wr_data_reg == 8'h00 && wr_en_reg;
    endproperty
    a_inc_wrap: assert property (p_inc_wrap) else $error("increment did not wrap"); // RULE5

    property p_inc_one_cycle;
        accept && is_inc_byte |=> s_one_cycle ##0 pc_next_reg == $past(pc) + {14'h0000, instr_length_reg};
    endproperty
    a_inc_one_cycle: assert property (p_inc_one_cycle) else $error("increment not one cycle"); // RULE6

    property p_ptr_inc;
        accept && is_inc_ptr |-> ##2 pointer_wr_reg && !wr_en_reg && pointer_out_reg == $past(data_pointer, 2) + 16'd1;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer increment wrong"); // RULE7

    property p_bit_fall;
        accept && is_bit_jump && !bit_pin |=>
            pc_next_reg == $past(pc) + 16'd3 ##1 done_reg && !wr_en_reg && !bit_clear_reg;
    endproperty
    a_bit_fall: assert property (p_bit_fall) else $error("bit test fall-through wrong"); // RULE8

    property p_bit_taken;
        accept && is_bit_jump && bit_pin |=>
            branch_taken_reg && pc_next_reg == $past(pc) + 16'd3 + {{8{$past(operand_2[7])}}, $past(operand_2)};
    endproperty
    a_bit_taken: assert property (p_bit_taken) else $error("bit test branch target wrong"); // RULE8

    property p_clear_latch;
        accept && is_clear_jump && bit_is_port && bit_latch && !bit_pin |-> ##2 bit_clear_reg && branch_taken_reg;
    endproperty
    a_clear_latch: assert property (p_clear_latch) else $error("clearing test ignored latch"); // RULE10

    property p_clear_zero;
        accept && is_clear_jump && !clear_test_bit |-> ##2 done_reg && !bit_clear_reg;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("zero bit was cleared"); // RULE9

    property p_clear_taken;
        accept && is_clear_jump && clear_test_bit |=>
            pc_next_reg == $past(pc) + 16'd3 + {{8{$past(operand_2[7])}}, $past(operand_2)} ##1 s_clear_pulse;
    endproperty
    a_clear_taken: assert property (p_clear_taken) else $error("clearing branch wrong"); // RULE9

    property p_carry_taken;
        accept && is_carry_jump && carry |=>
            pc_next_reg == $past(pc) + 16'd2 + {{8{$past(operand_1[7])}}, $past(operand_1)};
    endproperty
    a_carry_taken: assert property (p_carry_taken) else $error("carry branch target wrong"); // RULE11

    property p_jmp_ind;
        accept && is_jmp_ind |-> ##2 done_reg && !wr_en_reg && !pointer_wr_reg &&
            pc_next_reg == $past(data_pointer, 2) + {8'h00, $past(acc, 2)};
    endproperty
    a_jmp_ind: assert property (p_jmp_ind) else $error("indirect jump target wrong"); // RULE12

    property p_decode_dir;
        accept && opcode == 8'hd5 |=> !unknown_op_reg && instr_length_reg == 2'd3 && wr_target_reg == TGT_DIRECT;
    endproperty
    a_decode_dir: assert property (p_decode_dir) else $error("direct decrement decode wrong"); // RULE13

endmodule

// ### tb_loop_increment_branch_exec.sv
module tb_loop_increment_branch_exec
    import loop_branch_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk, rst_b, start, carry, operand_is_port, bit_pin, bit_latch, bit_is_port;
    logic [7:0]  opcode, operand_1, operand_2, acc, reg_value, mem_value, latch_value;
    logic [15:0] pc, data_pointer;
    logic        busy, done, unknown_op, branch_taken, wr_en, ind_select, pointer_wr, bit_clear;
    logic [15:0] pc_next, pointer_out, e_pc, e_dp;
    logic [1:0]  instr_length, e_len, e_cyc;
    target_e     wr_target, e_tgt;
    logic [2:0]  reg_select;
    logic [7:0]  wr_data, e_wd, s_op;
    logic        e_bt, e_unk, e_we, e_dw, e_bc;
    int          bad_count = 0;
    int          n_tests = 0;
    bit          hung = 1'b0;
    // Unknown codes at the end keep the refusal path in the mix
    logic [7:0]  ops [14] = '{8'hd8, 8'hd5, 8'h04, 8'h08, 8'h05, 8'h06, 8'ha3,
                              8'h20, 8'h10, 8'h40, 8'h73, 8'h14, 8'h30, 8'h00};

    loop_increment_branch_exec i_loop_increment_branch_exec (.*);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic complete_run();
        if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [15:0] ex, input logic [15:0] got);
        n_tests++;
        if (got !== ex) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic chk_flag(input string nm, input logic ex, input logic got);
        n_tests++;
        if (got !== ex) begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", nm, ex, got);
        end
    endtask

    // Boundary bytes are favoured: wrap and zero cases hide there
    function automatic logic [7:0] pick();
        case ($urandom % 4)
            0: return 8'h00;
            1: return 8'h01;
            2: return 8'hff;
            default: return 8'($urandom);
        endcase
    endfunction

    task automatic drive(input int idx);
        logic [7:0] o;
        o = ops[idx % 14];
        if (o == 8'hd8 || o == 8'h08) o = o | 8'($urandom % 8);
        if (o == 8'h06) o = o | 8'($urandom % 2);
        opcode <= o;
        start <= 1'b1;
        operand_1 <= pick();
        operand_2 <= pick();
        pc <= {pick(), pick()};
        data_pointer <= {pick(), pick()};
        acc <= pick();
        reg_value <= pick();
        mem_value <= pick();
        latch_value <= pick();
        carry <= 1'($urandom);
        operand_is_port <= 1'($urandom);
        bit_pin <= 1'($urandom);
        bit_latch <= 1'($urandom);
        bit_is_port <= 1'($urandom);
    endtask

    task automatic model();
        logic [7:0] src;
        logic [7:0] rel;
        logic       cond;
        s_op = opcode;
        e_unk = 1'b0;
        e_we = 1'b0;
        e_dw = 1'b0;
        e_bc = 1'b0;
        e_bt = 1'b0;
        e_cyc = 2'd2;
        e_len = 2'd1;
        e_tgt = TGT_NONE;
        e_wd = 8'h00;
        rel = 8'h00;
        cond = 1'b0;
        src = operand_is_port ? latch_value : mem_value;
        e_dp = data_pointer + 16'h0001;
        casez (opcode)
            8'b11011???: begin
                e_len = 2'd2;
                e_we = 1'b1;
                e_tgt = TGT_REG;
                e_wd = reg_value - 8'h01;
                cond = e_wd != 8'h00;
                rel = operand_1;
            end
            8'hd5: begin
                e_len = 2'd3;
                e_we = 1'b1;
                e_tgt = TGT_DIRECT;
                e_wd = src - 8'h01;
                cond = e_wd != 8'h00;
                rel = operand_2;
            end
            8'h04: begin
                e_cyc = 2'd1;
                e_we = 1'b1;
                e_tgt = TGT_ACC;
                e_wd = acc + 8'h01;
            end
            8'b00001???: begin
                e_cyc = 2'd1;
                e_we = 1'b1;
                e_tgt = TGT_REG;
                e_wd = reg_value + 8'h01;
            end
            8'h05: begin
                e_cyc = 2'd1;
                e_len = 2'd2;
                e_we = 1'b1;
                e_tgt = TGT_DIRECT;
                e_wd = src + 8'h01;
            end
            8'b0000011?: begin
                e_cyc = 2'd1;
                e_we = 1'b1;
                e_tgt = TGT_INDIRECT;
                e_wd = src + 8'h01;
            end
            8'ha3: e_dw = 1'b1;
            8'h20: begin
                e_len = 2'd3;
                cond = bit_pin;
                rel = operand_2;
            end
            8'h10: begin
                e_len = 2'd3;
                cond = bit_is_port ? bit_latch : bit_pin;
                e_bc = cond;
                rel = operand_2;
            end
            8'h40: begin
                e_len = 2'd2;
                cond = carry;
                rel = operand_1;
            end
            8'h73: e_bt = 1'b1;
            default: begin
                e_unk = 1'b1;
                e_cyc = 2'd1;
            end
        endcase
        e_bt = e_bt | cond;
        e_pc = pc + {14'h0000, e_len} + (cond ? {{8{rel[7]}}, rel} : 16'h0000);
        if (opcode == 8'h73) e_pc = {8'h00, acc} + data_pointer;
        if (e_unk) e_pc = pc;
    endtask

    // Hold keeps start up: a one-cycle op runs again at once, a two-cycle one must be ignored
    task automatic run_op(input int idx, input bit hold);
        int k;
        @(posedge clk);
        drive(idx);
        #1;
        model();
        @(posedge clk);
        if (!hold) start <= 1'b0;
        else if (e_cyc == 2'd2) opcode <= 8'h04;
        k = 0;
        repeat (3) begin
            #1;
            k++;
            if (k == 1) chk_flag("busy", e_cyc == 2'd2, busy);
            if (done === 1'b1) break;
            @(posedge clk);
            if (k == 1) start <= 1'b0;
        end
        if (done !== 1'b1) begin
            bad_count++;
            $display("[FAIL] done expected 1 seen %b", done);
            hung = 1'b1;
            return;
        end
        chk_word("cycles", {14'h0000, e_cyc}, 16'(k));
        chk_word("pc_next", e_pc, pc_next);
        chk_flag("branch_taken", e_bt, branch_taken);
        chk_flag("unknown_op", e_unk, unknown_op);
        chk_flag("wr_en", e_we, wr_en);
        chk_flag("pointer_wr", e_dw, pointer_wr);
        chk_flag("bit_clear", e_bc, bit_clear);
        if (!e_unk) chk_word("instr_length", {14'h0000, e_len}, {14'h0000, instr_length});
        if (e_we) chk_word("wr_data", {8'h00, e_wd}, {8'h00, wr_data});
        if (e_we) chk_word("wr_target", {13'h0000, e_tgt}, {13'h0000, wr_target});
        if (e_tgt == TGT_REG) chk_word("reg_select", {13'h0000, s_op[2:0]}, {13'h0000, reg_select});
        if (e_tgt == TGT_INDIRECT) chk_flag("ind_select", s_op[0], ind_select);
        if (e_dw) chk_word("pointer_out", e_dp, pointer_out);
        if (hold) begin
            @(posedge clk);
            start <= 1'b0;
            #1;
            chk_flag("done", e_cyc == 2'd1, done);
        end
    endtask

    initial begin
        rst_b = 1'b0;
        start = 1'b0;
        opcode = 8'h00;
        operand_1 = 8'h00;
        operand_2 = 8'h00;
        pc = 16'h0000;
        acc = 8'h00;
        data_pointer = 16'h0000;
        carry = 1'b0;
        reg_value = 8'h00;
        mem_value = 8'h00;
        latch_value = 8'h00;
        operand_is_port = 1'b0;
        bit_pin = 1'b0;
        bit_latch = 1'b0;
        bit_is_port = 1'b0;
        void'($urandom(90));
        repeat (10) @(posedge clk);
        #1;
        chk_flag("busy", 1'b0, busy);
        chk_flag("done", 1'b0, done);
        chk_word("pc_next", 16'h0000, pc_next);
        chk_word("instr_length", 16'h0001, {14'h0000, instr_length});
        @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 420 && !hung; i++) begin
            run_op(i, ($urandom % 3) == 0);
        end
        complete_run();
    end
endmodule
